// >>> common/eewp_defs.vh
// Constants for the two-wire EEPROM write and protection slave
`ifndef EEWP_DEFS_VH
`define EEWP_DEFS_VH
`define EEWP_DEV_TYPE        4'hB    // Device-type code, value is arbitrary
`define EEWP_PTR_ADDR        11'h7FF
`define EEWP_PTR_RESET       8'hFF
`define EEWP_PROT_FLAG_BIT   2
`define EEWP_MULTI_MAX       4'h8
`define EEWP_CLK_MHZ         100
`define EEWP_TW_MS           10
`define EEWP_TW_CYCLES       (`EEWP_TW_MS * 1000 * `EEWP_CLK_MHZ)
`endif

// >>> logic/eewp_slave.v
// Two-wire EEPROM slave: write modes, program cycle, block protection
`timescale 1ns/1ns
`default_nettype none
`include "eewp_defs.vh"

// Overview of operation
// RL1 - SDA falling while SCL high is start
// RL2 - Ignore bus until start, outside programming
// RL3 - SDA rising while SCL high is stop
// RL4 - Stop after read returns to standby
// RL5 - Stop after write starts program cycle
// RL6 - Receiver pulls SDA low on ninth clock
// RL7 - Capture SDA on each SCL rising edge
// RL8 - Master changes SDA only while SCL low
// RL9 - Select byte: type, block, direction bit
// RL10 - Mode pin high multibyte, low page
// RL11 - Acknowledge select, take and acknowledge address
// RL12 - Write inhibit blocks memory and data acknowledge
// RL13 - Single byte write works in either mode
// RL14 - Multibyte accepts one to eight bytes
// RL15 - Multibyte cycle 10ms, 20ms over rows
// RL16 - Over eight multibyte bytes may corrupt row
// RL17 - Page mode wraps low four address bits
// RL18 - Program cycle ignores all bus inputs
// RL19 - No select acknowledge while programming
// RL20 - Pointer upper nibble sets protect boundary
// RL21 - Block pins choose boundary block four-seven
// RL22 - Protect only if enable high, flag zero
// RL23 - Program time counter is a parameter
module eewp_slave #(
    // RL23 program time counter length
    parameter TW_CYCLES = `EEWP_TW_CYCLES
) (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        srst,
    // Serial bus, open drain data
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_out,
    output reg         sda_oe_n,
    // Strap and control pins
    input  wire        write_mode_multi,
    input  wire        write_inhibit_pin,
    input  wire        protect_enable,
    input  wire        protect_block_sel_lo,
    input  wire        protect_block_sel_hi,
    // Status
    output reg         busy_q
);
    localparam S_IDLE = 6'h01;
    localparam S_SEL  = 6'h02;
    localparam S_ADDR = 6'h04;
    localparam S_DATA = 6'h08;
    localparam S_READ = 6'h10;
    localparam S_IGN  = 6'h20;

    // =========================================
    // Input synchronisers
    reg  [2:0] scl_sync_q;
    reg  [2:0] sda_sync_q;
    reg        scl_q;
    reg        sda_q;
    reg  [4:0] pin_s1_q;
    reg  [4:0] pin_s2_q;
    reg  [4:0] pin_s3_q;
    reg  [4:0] pin_q;
    // Three stages; level changes only when the last two agree
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            scl_sync_q <= 3'h7;
            sda_sync_q <= 3'h7;
            scl_q      <= 1'b1;
            sda_q      <= 1'b1;
            pin_s1_q   <= 5'h00;
            pin_s2_q   <= 5'h00;
            pin_s3_q   <= 5'h00;
            pin_q      <= 5'h00;
        end
        else
        begin
            scl_sync_q <= {scl_sync_q[1:0], scl_in};
            sda_sync_q <= {sda_sync_q[1:0], sda_in};
            // Straps packed block hi, block lo, enable, inhibit, mode; a bit moves when the last two stages agree
            pin_s1_q   <= {protect_block_sel_hi, protect_block_sel_lo, protect_enable, write_inhibit_pin, write_mode_multi};
            pin_s2_q   <= pin_s1_q;
            pin_s3_q   <= pin_s2_q;
            pin_q      <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q | pin_s3_q));
            if (scl_sync_q[1] == scl_sync_q[2])
                scl_q <= scl_sync_q[2];
            if (sda_sync_q[1] == sda_sync_q[2])
                sda_q <= sda_sync_q[2];
        end
    end

    // Filtered levels delayed a cycle for edge detection
    reg scl_d1_q;
    reg sda_d1_q;
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            scl_d1_q <= 1'b1;
            sda_d1_q <= 1'b1;
        end
        else
        begin
            scl_d1_q <= scl_q;
            sda_d1_q <= sda_q;
        end
    end

    wire scl_rise = scl_q & ~scl_d1_q;
    wire scl_fall = ~scl_q & scl_d1_q;
    // RL1 start detect
    wire start_det = scl_q & scl_d1_q & sda_d1_q & ~sda_q;
    // RL3 stop detect
    wire stop_det  = scl_q & scl_d1_q & ~sda_d1_q & sda_q;

    // =========================================
    // Memory and write latches
    reg [7:0]  mem [0:2047];
    reg [7:0]  latch_data [0:15];
    reg [15:0] latch_vld_q;
    reg [6:0]  row_q;          // Block and upper address nibble of write row
    reg        row_cross_q;    // Multibyte write spilled into next row
    reg [7:0]  ptr_q;          // Copy of the pointer byte held at the top address

    // =========================================
    // Protocol state
    reg [5:0]  state_q;
    reg [3:0]  bit_cnt_q;
    reg [7:0]  shift_q;
    reg [2:0]  block_q;
    reg [7:0]  addr_q;
    reg [3:0]  nbytes_q;
    reg        inhibit_q;
    reg        ack_phase_q;
    reg        ack_drive_q;
    reg        ack_slot_q;     // Ninth clock slot is open
    reg        wrote_q;
    reg        multi_q;
    reg [31:0] tw_cnt_q;

    wire [7:0] rx_byte = {shift_q[6:0], sda_q};

    // RL21 boundary block from the two pins
    wire [2:0]  prot_block = {1'b1, pin_q[4], pin_q[3]};
    // RL20 boundary in 16-byte steps from the upper pointer nibble
    wire [10:0] prot_base  = {prot_block, ptr_q[7:4], 4'h0};
    // RL22 protection active only with enable high and flag clear
    wire        prot_on    = pin_q[2] & ~ptr_q[`EEWP_PROT_FLAG_BIT];

    // Protection test on a full address
    function is_prot;
        input [10:0] a;
        begin
            is_prot = prot_on & (a >= prot_base);
        end
    endfunction

    integer i;
    // Main protocol machine
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            state_q     <= S_IDLE;
            bit_cnt_q   <= 4'h0;
            shift_q     <= 8'h00;
            block_q     <= 3'h0;
            addr_q      <= 8'h00;
            nbytes_q    <= 4'h0;
            inhibit_q   <= 1'b0;
            ack_phase_q <= 1'b0;
            ack_drive_q <= 1'b0;
            ack_slot_q  <= 1'b0;
            wrote_q     <= 1'b0;
            multi_q     <= 1'b0;
            busy_q      <= 1'b0;
            tw_cnt_q    <= 32'h0;
            latch_vld_q <= 16'h0;
            row_q       <= 7'h00;
            row_cross_q <= 1'b0;
            ptr_q       <= `EEWP_PTR_RESET;
            sda_out     <= 1'b0;
            sda_oe_n    <= 1'b1;
        end
        else if (busy_q)
        begin
            // RL18 bus ignored while programming
            // RL19 no select acknowledge while busy
            // RL15 doubled time when multibyte crossed a row
            sda_oe_n <= 1'b1;
            state_q  <= S_IDLE;
            if (tw_cnt_q >= (row_cross_q ? 2 * TW_CYCLES - 1 : TW_CYCLES - 1))
            begin
                busy_q <= 1'b0;
                // Commit every valid latch; protection was tested on addr_q as each byte was latched
                for (i = 0; i < 16; i = i + 1)
                    if (latch_vld_q[i])
                    begin
                        mem[{row_q, i[3:0]}] <= latch_data[i];
                        if ({row_q, i[3:0]} == `EEWP_PTR_ADDR)
                            ptr_q <= latch_data[i];
                    end
                latch_vld_q <= 16'h0;
            end
            else
                tw_cnt_q <= tw_cnt_q + 32'h1;
        end
        else if (start_det)
        begin
            // RL2 every frame begins at a start
            state_q     <= S_SEL;
            bit_cnt_q   <= 4'h0;
            ack_phase_q <= 1'b0;
            ack_drive_q <= 1'b0;
            ack_slot_q  <= 1'b0;
            sda_oe_n    <= 1'b1;
            // RL12 inhibit sampled from start through the address byte
            inhibit_q   <= pin_q[1];
            wrote_q     <= 1'b0;
        end
        else if (stop_det)
        begin
            sda_oe_n <= 1'b1;
            state_q  <= S_IDLE;
            // RL5 stop after written data starts the cycle
            // RL4 any other stop just goes to standby
            if (wrote_q && latch_vld_q != 16'h0)
            begin
                busy_q   <= 1'b1;
                tw_cnt_q <= 32'h0;
            end
            else
                latch_vld_q <= 16'h0;
            wrote_q <= 1'b0;
        end
        else
        begin
            if (pin_q[1] && (state_q == S_SEL || state_q == S_ADDR))
                inhibit_q <= 1'b1;
            // RL7 sample data on SCL rising edge
            if (scl_rise && !ack_phase_q && state_q != S_IDLE && state_q != S_IGN)
            begin
                shift_q   <= rx_byte;
                bit_cnt_q <= bit_cnt_q + 4'h1;
                if (bit_cnt_q == 4'h7)
                begin
                    bit_cnt_q   <= 4'h0;
                    ack_phase_q <= 1'b1;
                    ack_drive_q <= 1'b0;
                    case (state_q)
                        S_SEL:
                        begin
                            // RL9 type, block and direction decode
                            if (rx_byte[7:4] == `EEWP_DEV_TYPE)
                            begin
                                block_q     <= rx_byte[3:1];
                                ack_drive_q <= 1'b1;
                                state_q     <= rx_byte[0] ? S_READ : S_ADDR;
                            end
                            else
                                state_q <= S_IGN;
                        end
                        S_ADDR:
                        begin
                            // RL11 byte address taken and acknowledged
                            addr_q      <= rx_byte;
                            ack_drive_q <= 1'b1;
                            nbytes_q    <= 4'h0;
                            row_q       <= {block_q, rx_byte[7:4]};
                            row_cross_q <= 1'b0;
                            // RL10 mode pin read at each write
                            multi_q     <= pin_q[0];
                            state_q     <= S_DATA;
                        end
                        S_DATA:
                        begin
                            // RL12 inhibited writes stay silent
                            if (!inhibit_q)
                            begin
                                // RL13 RL14 each data byte acknowledged
                                ack_drive_q <= 1'b1;
                                wrote_q     <= 1'b1;
                                nbytes_q    <= nbytes_q + 4'h1;
                                if (!is_prot({block_q, addr_q}))
                                begin
                                    latch_data[addr_q[3:0]]  <= rx_byte;
                                    latch_vld_q[addr_q[3:0]] <= 1'b1;
                                end
                                // RL17 page mode wraps in the row
                                if (!multi_q)
                                    addr_q[3:0] <= addr_q[3:0] + 4'h1;
                                else
                                begin
                                    // RL16 a byte landing past the row end marks the cross
                                    addr_q <= addr_q + 8'h01;
                                    if (addr_q[3:0] == 4'h0 && nbytes_q != 4'h0)
                                        row_cross_q <= 1'b1;
                                end
                            end
                        end
                        default:
                            state_q <= S_IGN;
                    endcase
                end
            end
            // RL6 drive low over ninth clock, release after
            if (scl_fall && ack_phase_q)
            begin
                if (!ack_slot_q)
                begin
                    // Slot opens even for a refused byte, so its ninth pulse is never taken as data
                    ack_slot_q <= 1'b1;
                    sda_out    <= 1'b0;
                    sda_oe_n   <= ~ack_drive_q;
                end
                else
                begin
                    ack_slot_q  <= 1'b0;
                    sda_oe_n    <= 1'b1;
                    ack_phase_q <= 1'b0;
                    ack_drive_q <= 1'b0;
                    if (state_q == S_READ)
                        state_q <= S_IGN;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> sim/eewp_checker.sv
// Concurrent checks on the pins of the two-wire EEPROM slave
`timescale 1ns/1ns
`default_nettype none
module eewp_checker #(
    parameter int TW_CYCLES = 50
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    // Strap and control pins
    input wire logic write_mode_multi,
    input wire logic write_inhibit_pin,
    input wire logic protect_enable,
    input wire logic protect_block_sel_lo,
    input wire logic protect_block_sel_hi,
    // Status
    input wire logic busy_q
);
    // ==========
    // Program cycle length counter
    int cnt_q;
    always @(posedge ref_clk)
        cnt_q <= (srst || !busy_q) ? 0 : cnt_q + 1;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    a_ack_scl_low: assert property ($fell(sda_oe_n) |-> !scl_in)
        else $error("ack pulled while clock high");
    a_ack_hold: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8])
        else $error("ack shorter than a clock pulse");
    a_ack_release: assert property ($fell(sda_oe_n) |-> ##[8:20] sda_oe_n)
        else $error("ack never released");
    a_release_scl_low: assert property ($rose(sda_oe_n) && !$past(srst) |-> !scl_in)
        else $error("ack released while clock high");
    a_ack_level: assert property (!sda_oe_n |-> !sda_out)
        else $error("ack driven high");
    a_busy_quiet: assert property (busy_q |-> sda_oe_n)
        else $error("bus answered while programming");
    a_busy_length: assert property ($fell(busy_q) && !$past(srst) |-> cnt_q == TW_CYCLES || cnt_q == 2 * TW_CYCLES)
        else $error("program cycle length wrong");
    a_busy_cap: assert property (busy_q |-> cnt_q < 2 * TW_CYCLES)
        else $error("program cycle overran");
    a_busy_after_stop: assert property ($rose(busy_q) |-> scl_in && sda_in && !$past(sda_in, 7))
        else $error("program cycle without stop");
    a_reset_quiet: assert property ($fell(srst) |-> sda_oe_n && !busy_q)
        else $error("not idle after reset");
    // Main scenarios reached
    c_ack: cover property ($fell(sda_oe_n));
    c_cycle: cover property ($rose(busy_q));
    c_double: cover property ($fell(busy_q) && cnt_q == 2 * TW_CYCLES);
endmodule
bind eewp_slave eewp_checker #(.TW_CYCLES(TW_CYCLES)) chk_u (.ref_clk(ref_clk), .srst(srst), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .write_mode_multi(write_mode_multi),
    .write_inhibit_pin(write_inhibit_pin), .protect_enable(protect_enable),
    .protect_block_sel_lo(protect_block_sel_lo), .protect_block_sel_hi(protect_block_sel_hi), .busy_q(busy_q));
`default_nettype wire

// >>> sim/eewp_master.sv
// Bus master model driving the serial clock and data of the slave
`timescale 1ns/1ns
`default_nettype none
module eewp_master (
    // Clock and sampled wire
    input  wire logic ref_clk,
    input  wire logic sda_in,
    // Driven pins, high means released to the pull-up
    output var  logic scl_out,
    output var  logic sda_drv
);
    // ==========
    // Bus idles released; the clock stands high between frames
    initial
    begin
        scl_out = 1'h1;
        sda_drv = 1'h1;
    end
    // Quarters of the 80 ns bus clock period
    task automatic q(input int n);
        repeat (2 * n) @(posedge ref_clk);
    endtask
    task automatic start;
        sda_drv <= 1'h1;
        q(1);
        scl_out <= 1'h1;
        q(1);
        sda_drv <= 1'h0;
        q(1);
        scl_out <= 1'h0;
        q(1);
    endtask
    // data moves while low, ninth pulse released
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            sda_drv <= b[i];
            q(1);
            scl_out <= 1'h1;
            q(2);
            scl_out <= 1'h0;
            q(1);
        end
        // Low phase stretched so the slave's synchroniser settles the ack
        sda_drv <= 1'h1;
        q(3);
        scl_out <= 1'h1;
        q(2);
        ack = ~sda_in;
        scl_out <= 1'h0;
        q(3);
    endtask
    task automatic stop;
        sda_drv <= 1'h0;
        q(1);
        scl_out <= 1'h1;
        q(1);
        sda_drv <= 1'h1;
        q(2);
    endtask
endmodule
`default_nettype wire

// >>> sim/eewp_slave_tb_top.sv
// Self-checking bench for the two-wire EEPROM write and protection slave
`timescale 1ns/1ns
`default_nettype none
`include "eewp_defs.vh"
module eewp_slave_tb_top;
    // ==========
    // Pins and bookkeeping
    localparam int TW = 200;
    logic        ref_clk;
    logic        srst   = 1'h1;
    logic        mode_q = 1'h0;
    logic        inh_q  = 1'h0;
    logic [1:0]  blk_q  = 2'h0;
    logic        pre_q  = 1'h0;
    logic [7:0]  ptr_b  = 8'hFF;
    logic        ack;
    logic [10:0] a;
    wire         scl;
    wire         m_sda;
    wire         sda_out;
    wire         sda_oe_n;
    wire         busy_q;
    wire         sda_w = m_sda & (sda_oe_n | sda_out);
    int          miscompares = 0;
    int          check_count = 0;
    int          cycles      = 0;
    int          run_n       = 0;
    int          last_n      = 0;
    // Memory is not readable: a blocked write shows as a stop that starts no program cycle
    eewp_slave #(.TW_CYCLES(TW)) dut_u (.ref_clk(ref_clk), .srst(srst), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .write_mode_multi(mode_q), .write_inhibit_pin(inh_q),
        .protect_enable(pre_q), .protect_block_sel_lo(blk_q[0]), .protect_block_sel_hi(blk_q[1]), .busy_q(busy_q));
    eewp_master mst_u (.ref_clk(ref_clk), .sda_in(sda_w), .scl_out(scl), .sda_drv(m_sda));
    initial
    begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Busy run length and hang guard
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        run_n <= busy_q ? run_n + 1 : 0;
        if (!busy_q && run_n != 0)
            last_n <= run_n;
        if (cycles == 40000)
        begin
            miscompares++;
            $display("Error %0t: timeout", $time);
            close_out();
        end
    end
    task automatic close_out;
        $display("compares %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk_ack(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %0t: ack/busy %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_len(input int got, input int exp);
        check_count++;
        if (got != exp)
        begin
            miscompares++;
            $display("Error %0t: busy %0d expected %0d", $time, got, exp);
        end
    endtask
    // Multibyte writes spilling into the next row take double time
    function automatic int exp_tw(input logic m, input logic [10:0] s, input int n);
        logic [10:0] e;
        e = s + 11'(n - 1);
        return (m && e[10:4] != s[10:4]) ? 2 * TW : TW;
    endfunction
    // Select only, then stop
    task automatic sel(input logic [7:0] b, input logic exp);
        mst_u.start();
        mst_u.send(b, ack);
        chk_ack(ack, exp);
        mst_u.stop();
    endtask
    // Select, address and n data bytes, then stop
    task automatic wr(input logic [10:0] s, input int n, input logic dack);
        mst_u.start();
        mst_u.send({`EEWP_DEV_TYPE, s[10:8], 1'h0}, ack);
        chk_ack(ack, 1'h1);
        mst_u.send(s[7:0], ack);
        chk_ack(ack, 1'h1);
        for (int i = 0; i < n; i++)
        begin
            // A write starting at the top address carries the chosen pointer byte first
            mst_u.send((s == 11'h7FF && i == 0) ? ptr_b : 8'($urandom), ack);
            chk_ack(ack, dack);
        end
        mst_u.stop();
    endtask
    // Polled while programming, then length checked and ready answered
    task automatic cyc(input int exp);
        repeat (12) @(posedge ref_clk);
        chk_ack(busy_q, exp != 0);
        if (exp != 0)
        begin
            sel({`EEWP_DEV_TYPE, 4'h0}, 1'h0);
            for (int k = 0; k < 900 && busy_q; k++)
                @(posedge ref_clk);
            repeat (2) @(posedge ref_clk);
            chk_len(last_n, exp);
            sel({`EEWP_DEV_TYPE, 4'h0}, 1'h1);
        end
    endtask
    initial
    begin
        void'($urandom(81411));
        repeat (8) @(posedge ref_clk);
        srst <= 1'h0;
        repeat (4) @(posedge ref_clk);
        // Page, multibyte, forced row crossing, single bytes in both modes
        for (int t = 0; t < 6; t++)
        begin
            a = 11'($urandom);
            if (t == 3)
                a[3:0] = 4'hC;
            mode_q <= t[0];
            blk_q <= 2'($urandom);
            wr(a, (t > 3) ? 1 : (t[0] ? 8 : 16), 1'h1);
            cyc(exp_tw(t[0], a, (t > 3) ? 1 : 8));
            $display("test %0d done", t);
        end
        // Inhibit held from start through address: data refused, no cycle
        inh_q <= 1'h1;
        wr(11'($urandom), 2, 1'h0);
        cyc(0);
        inh_q <= 1'h0;
        // Foreign type code ignored; read select answered, no cycle
        sel({4'($urandom % 10), 4'h0}, 1'h0);
        sel({`EEWP_DEV_TYPE, 4'h1}, 1'h1);
        cyc(0);
        $display("test 6 done");
        // Pointer with flag clear written while unprotected, then the enable pin guards the range
        ptr_b = {4'($urandom), 4'h0};
        wr(11'h7FF, 1, 1'h1);
        cyc(TW);
        a = {1'h1, 2'($urandom), ptr_b[7:4], 4'h0};
        blk_q <= a[9:8];
        pre_q <= 1'h1;
        wr(a, 1, 1'h1);
        cyc(0);
        wr(a - 11'h010, 1, 1'h1);
        cyc(TW);
        $display("test 7 done");
        // Enable pin low again: the boundary row writes normally
        pre_q <= 1'h0;
        wr(a, 1, 1'h1);
        cyc(TW);
        $display("test 8 done");
        close_out();
    end
endmodule
`default_nettype wire
